/* src/alnum_params.svh */
/*
  Constants shared by both ends of the display memory port: area codes,
  bit positions, reset values, timing counts and host register offsets.
  Assumes it is included by bare name from the package and design files.
*/
`ifndef ALNUM_PARAMS_SVH
`define ALNUM_PARAMS_SVH

// area select codes: {attr_select_n, addr_lines[4:3]}
`define AREA_CHAR        3'h7
`define AREA_PTR         3'h4
`define AREA_ROW         3'h5
`define AREA_CTRL        3'h6
// field positions
`define CHR_SRC_BIT      7
`define CHR_ASCII_MSB    6
`define CHR_GLYPH_MSB    3
`define ROW_DOTS_MSB     4
`define PTR_SLOT_MSB     3
`define CTRL_FLASH_BIT   3
`define CTRL_BLINK_BIT   4
`define ATTR_DATA_BIT    0
// reset values
`define CHR_BLANK        8'h20
`define PTR_RESET        8'h00
`define CTRL_RESET       8'h00
// flash: rate is display clock / 28672, phase toggles at half period
`define FLASH_RATIO      28672
`define DISP_DIV_DEF     2180
// host bus cycle timing, in clk_sys cycles
`define HOST_SETUP_CYC   3'h1
`define HOST_STROBE_CYC  3'h3
`define HOST_HOLD_CYC    3'h1
`define HOST_GAP_CYC     3'h1
// host APB register offsets and fields
`define REG_CMD          12'h000
`define REG_STATUS       12'h004
`define REG_CTRL         12'h008
`define CMD_DIR_BIT      16
`define CMD_ASEL_BIT     13
`define BUS_IDLE_DATA    8'hff

`endif

/* src/alnum_pkg.sv */
/*
  Types for the display memory port: host state enum and the
  state structs of both ends.
  Assumes alnum_params.svh is on the include path.
*/
`include "alnum_params.svh"

package alnum_pkg;

  typedef enum logic [2:0]
  {
    HOST_IDLE   = 3'b000,
    HOST_SETUP  = 3'b001,
    HOST_STROBE = 3'b010,
    HOST_HOLD   = 3'b011,
    HOST_GAP    = 3'b100
  } host_state_e;

  typedef struct packed
  {
    logic [7:0][7:0]       chr;
    logic [7:0]            attr;
    logic [7:0]            ptr;
    logic [7:0]            ctrl;
    logic [15:0][7:0][4:0] glyph;
    logic                  done;
    logic [7:0]            dout;
    logic                  dout_oe_n;
    logic [15:0]           div_cnt;
    logic [15:0]           fl_cnt;
    logic                  phase;
    logic [7:0]            lit;
    logic [7:0]            code;
    logic [4:0]            dots;
  } disp_state_s;

  typedef struct packed
  {
    host_state_e state;
    logic [2:0]  cnt;
    logic        ce_n;
    logic        rd_n;
    logic        wr_n;
    logic        asel_n;
    logic [4:0]  addr;
    logic [7:0]  hdata;
    logic        hoe_n;
    logic        dir_rd;
    logic [7:0]  rdata;
    logic        rst_n;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } host_state_s;

endpackage

/* src/alnum_bus_if.sv */
/*
  Parallel bus between host and display. The data lines are resolved here
  from both enables; an undriven bus reads as all ones (pull-ups).
  Assumes both ends share clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
`include "alnum_params.svh"

interface alnum_bus_if;
  logic       ce_n;
  logic       rd_n;
  logic       wr_n;
  logic       disp_rst_n;
  logic       attr_select_n;
  logic [4:0] addr_lines;
  logic [7:0] host_data;
  logic       host_data_oe_n;
  logic [7:0] dev_data;
  logic       dev_data_oe_n;
  logic [7:0] data_lines;

  // host wins a clash, which only a broken host can cause
  assign data_lines = !host_data_oe_n ? host_data :
                      !dev_data_oe_n ? dev_data : `BUS_IDLE_DATA;

  modport host
  (
    output ce_n, rd_n, wr_n, disp_rst_n, attr_select_n, addr_lines,
    output host_data, host_data_oe_n,
    input  data_lines
  );

  modport dev
  (
    input  ce_n, rd_n, wr_n, disp_rst_n, attr_select_n, addr_lines,
    input  data_lines,
    output dev_data, dev_data_oe_n
  );
endinterface

`default_nettype wire

/* src/alnum_display.sv */
/*
  Display end: character RAM, flash attribute RAM, custom glyph pointer,
  custom glyph row RAM, control word, flash divider and a scan port.
  Assumes the host runs on clk_sys and obeys the bus protocol; the ASCII
  glyph ROM sits downstream and is fed the 7-bit code from scan_code_q.
*/
// Operation
// - holds chars, attributes, decoder codes, sixteen glyphs
// - host uses chip-select plus one strobe
// - host keeps address stable while selected
// - low address bits pick digit, 000 leftmost
// - bit 7 selects ASCII or custom glyph
// - ASCII uses bits 0-6, glyph bits 0-3
// - pointer eight bits, low four pick slot
// - host loads pointer before row accesses
// - glyph needs pointer write plus seven rows
// - low address picks row, bits 0-4 dots
// - bit 0 rightmost column, bit 4 leftmost
// - attribute RAM has one bit per digit
// - attribute select low targets attribute RAM
// - attribute write bit 0 sets or clears flash
// - marked digit flashes only with enable bit
// - flash rate is display clock over 28672
// - select high, upper address 11 is characters
// - select high, upper address 00 is pointer
// - select high, upper address 01 is rows
// - host raises chip-select between cycles
`timescale 1ns/100ps
`default_nettype none
`include "alnum_params.svh"

module alnum_display
#(
  parameter int DISP_DIV    = `DISP_DIV_DEF,
  parameter int FLASH_RATIO = `FLASH_RATIO
)
(
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  alnum_bus_if.dev        bus,
  input  wire logic [2:0] scan_digit,
  input  wire logic [2:0] scan_row,
  output logic [7:0]      scan_code_q,
  output logic [4:0]      scan_dots_q,
  output logic [7:0]      digit_lit_q
);

  localparam logic [15:0] DIV_LAST  = 16'(DISP_DIV - 1);
  localparam logic [15:0] HALF_LAST = 16'(FLASH_RATIO / 2 - 1);

  alnum_pkg::disp_state_s s_q;
  alnum_pkg::disp_state_s s_d;

  logic [2:0] area;
  logic [2:0] idx;
  logic [3:0] slot;
  logic [7:0] din;
  logic       access;
  logic       tick;
  logic [7:0] rd_val;

  // area decode; attribute select low ignores the upper address pair
  always_comb
  begin
    area = bus.attr_select_n ? {1'b1, bus.addr_lines[4:3]} : 3'h0;
    idx  = bus.addr_lines[2:0];
    slot = s_q.ptr[`PTR_SLOT_MSB:0];
    din  = bus.data_lines;
    // exactly one strobe with the chip selected counts as an access
    access = !bus.ce_n && (bus.rd_n != bus.wr_n);
    tick   = (s_q.div_cnt == DIV_LAST);
  end

  // read multiplexer; unused upper bits of narrow areas read as zero
  always_comb
  begin
    rd_val = 8'h00;
    case (area)
      `AREA_CHAR: rd_val = s_q.chr[idx];
      `AREA_PTR:  rd_val = s_q.ptr;
      `AREA_ROW:  rd_val = {3'h0, s_q.glyph[slot][idx]};
      `AREA_CTRL: rd_val = s_q.ctrl;
      default:    rd_val = {7'h00, s_q.attr[idx]};
    endcase
  end

  // next state: bus access, flash timing, scan output
  always_comb
  begin
    s_d = s_q;

    // display clock enable, then the flash phase from it
    s_d.div_cnt = tick ? 16'h0000 : 16'(s_q.div_cnt + 16'h0001);
    if (tick)
    begin
      // phase toggles every half flash period of display ticks
      if (s_q.fl_cnt == HALF_LAST)
      begin
        s_d.fl_cnt = 16'h0000;
        s_d.phase  = !s_q.phase;
      end
      else
      begin
        s_d.fl_cnt = 16'(s_q.fl_cnt + 16'h0001);
      end
    end

    // one action per chip-select period; done clears when deselected
    if (bus.ce_n)
    begin
      s_d.done      = 1'b0;
      s_d.dout_oe_n = 1'b1;
    end
    else if (access && !s_q.done)
    begin
      s_d.done = 1'b1;
      if (!bus.wr_n)
      begin
        case (area)
          `AREA_CHAR: s_d.chr[idx] = din;
          `AREA_PTR:  s_d.ptr = din;
          `AREA_ROW:  s_d.glyph[slot][idx] = din[`ROW_DOTS_MSB:0];
          `AREA_CTRL: s_d.ctrl = din;
          default:    s_d.attr[idx] = din[`ATTR_DATA_BIT];
        endcase
      end
      else
      begin
        s_d.dout      = rd_val;
        s_d.dout_oe_n = 1'b0;
      end
    end
    else if (bus.rd_n)
    begin
      // release the bus as soon as the read strobe goes away
      s_d.dout_oe_n = 1'b1;
    end

    // display reset pin blanks the text and clears attributes and control
    if (!bus.disp_rst_n)
    begin
      for (int i = 0; i < 8; i++)
      begin
        s_d.chr[i] = `CHR_BLANK;
      end
      s_d.attr   = 8'h00;
      s_d.ctrl   = `CTRL_RESET;
      s_d.fl_cnt = 16'h0000;
      s_d.phase  = 1'b0;
    end

    // scan port: bit 7 routes the digit to the glyph RAM or the decoder
    s_d.code = s_q.chr[scan_digit];
    if (s_q.chr[scan_digit][`CHR_SRC_BIT])
    begin
      // bit 4 of a row is the leftmost column, bit 0 the rightmost
      s_d.dots = s_q.glyph[s_q.chr[scan_digit][`CHR_GLYPH_MSB:0]][scan_row];
    end
    else
    begin
      s_d.dots = 5'h00;
    end
    // blink overrides flash; flash only applies with the enable bit set
    for (int i = 0; i < 8; i++)
    begin
      s_d.lit[i] = !(s_q.phase && (s_q.ctrl[`CTRL_BLINK_BIT] ||
                   (s_q.ctrl[`CTRL_FLASH_BIT] && s_q.attr[i])));
    end
  end

  // single state register
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q           <= '0;
      s_q.chr       <= {8{`CHR_BLANK}};
      s_q.ptr       <= `PTR_RESET;
      s_q.dout_oe_n <= 1'b1;
      s_q.lit       <= 8'hff;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign bus.dev_data      = s_q.dout;
  assign bus.dev_data_oe_n = s_q.dout_oe_n;
  assign scan_code_q       = s_q.code;
  assign scan_dots_q       = s_q.dots;
  assign digit_lit_q       = s_q.lit;

endmodule

`default_nettype wire

/* src/alnum_host.sv */
/*
  Host end: an APB slave takes one bus command at a time and runs one
  chip-select cycle on the parallel display bus.
  Assumes the display shares clk_sys; one command per command write.
*/
`timescale 1ns/100ps
`default_nettype none
`include "alnum_params.svh"

module alnum_host
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  alnum_bus_if.host        bus
);

  alnum_pkg::host_state_s s_q;
  alnum_pkg::host_state_s s_d;

  logic apb_take;
  logic busy;
  logic mapped;

  // next state: apb slave plus display bus sequencer
  always_comb
  begin
    s_d      = s_q;
    busy     = (s_q.state != alnum_pkg::HOST_IDLE);
    apb_take = psel && penable && s_q.pready;
    mapped   = (paddr == `REG_CMD) || (paddr == `REG_STATUS) ||
               (paddr == `REG_CTRL);

    // zero-wait answer: ready rises in the access phase
    s_d.pready  = psel && !penable && !s_q.pready;
    s_d.pslverr = psel && !penable && !mapped;
    s_d.prdata  = 32'h0000_0000;
    if (psel && !penable)
    begin
      case (paddr)
        `REG_STATUS: s_d.prdata = {16'h0000, s_q.rdata, 7'h00, busy};
        `REG_CTRL:   s_d.prdata = {31'h0, !s_q.rst_n};
        `REG_CMD:    s_d.prdata = {15'h0, s_q.dir_rd, 2'h0, s_q.asel_n,
                                   s_q.addr, s_q.hdata};
        default:     s_d.prdata = 32'h0000_0000;
      endcase
    end

    // register writes; a command while busy is dropped
    if (apb_take && pwrite)
    begin
      if (paddr == `REG_CTRL)
      begin
        s_d.rst_n = !pwdata[0];
      end
      else if (paddr == `REG_CMD && !busy)
      begin
        s_d.hdata  = pwdata[7:0];
        s_d.addr   = pwdata[12:8];
        s_d.asel_n = pwdata[`CMD_ASEL_BIT];
        s_d.dir_rd = pwdata[`CMD_DIR_BIT];
        s_d.state  = alnum_pkg::HOST_SETUP;
        s_d.cnt    = `HOST_SETUP_CYC;
      end
    end

    // address settles with chip-select, then one strobe, then release
    case (s_q.state)
      alnum_pkg::HOST_IDLE:
      begin
        s_d.ce_n  = 1'b1;
        s_d.rd_n  = 1'b1;
        s_d.wr_n  = 1'b1;
        s_d.hoe_n = 1'b1;
        if (s_d.state == alnum_pkg::HOST_SETUP)
        begin
          s_d.ce_n  = 1'b0;
          s_d.hoe_n = s_d.dir_rd;
        end
      end
      alnum_pkg::HOST_SETUP:
      begin
        s_d.cnt = 3'(s_q.cnt - 3'h1);
        if (s_q.cnt == 3'h1)
        begin
          s_d.state = alnum_pkg::HOST_STROBE;
          s_d.cnt   = `HOST_STROBE_CYC;
          s_d.rd_n  = !s_q.dir_rd;
          s_d.wr_n  = s_q.dir_rd;
        end
      end
      alnum_pkg::HOST_STROBE:
      begin
        s_d.cnt = 3'(s_q.cnt - 3'h1);
        if (s_q.cnt == 3'h1)
        begin
          s_d.state = alnum_pkg::HOST_HOLD;
          s_d.cnt   = `HOST_HOLD_CYC;
          s_d.rd_n  = 1'b1;
          s_d.wr_n  = 1'b1;
          if (s_q.dir_rd)
          begin
            s_d.rdata = bus.data_lines;
          end
        end
      end
      alnum_pkg::HOST_HOLD:
      begin
        s_d.cnt = 3'(s_q.cnt - 3'h1);
        if (s_q.cnt == 3'h1)
        begin
          // chip-select goes high between every two cycles
          s_d.state = alnum_pkg::HOST_GAP;
          s_d.cnt   = `HOST_GAP_CYC;
          s_d.ce_n  = 1'b1;
          s_d.hoe_n = 1'b1;
        end
      end
      alnum_pkg::HOST_GAP:
      begin
        s_d.cnt = 3'(s_q.cnt - 3'h1);
        if (s_q.cnt == 3'h1)
        begin
          s_d.state = alnum_pkg::HOST_IDLE;
        end
      end
      default:
      begin
        s_d.state = alnum_pkg::HOST_IDLE;
      end
    endcase
  end

  // single state register; nrst leaves the display reset pin released (rst_n high)
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q       <= '0;
      s_q.state <= alnum_pkg::HOST_IDLE;
      s_q.ce_n  <= 1'b1;
      s_q.rd_n  <= 1'b1;
      s_q.wr_n  <= 1'b1;
      s_q.hoe_n <= 1'b1;
      s_q.rst_n <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign prdata             = s_q.prdata;
  assign pready             = s_q.pready;
  assign pslverr            = s_q.pslverr;
  assign bus.ce_n           = s_q.ce_n;
  assign bus.rd_n           = s_q.rd_n;
  assign bus.wr_n           = s_q.wr_n;
  assign bus.disp_rst_n     = s_q.rst_n;
  assign bus.attr_select_n  = s_q.asel_n;
  assign bus.addr_lines     = s_q.addr;
  assign bus.host_data      = s_q.hdata;
  assign bus.host_data_oe_n = s_q.hoe_n;

endmodule

`default_nettype wire

/* test/alnum_display_memory_port_assertions.sv */
/*
  Wire checks on the parallel display bus between host and display.
  Assumes it sees the bus signals plus clk_sys and nrst.
*/
`timescale 1ns/100ps
`default_nettype none

module alnum_display_memory_port_assertions
(
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       ce_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       disp_rst_n,
  input wire logic       attr_select_n,
  input wire logic [4:0] addr_lines,
  input wire logic       host_data_oe_n,
  input wire logic [7:0] dev_data,
  input wire logic       dev_data_oe_n
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // host discipline: one strobe, inside a select, never during reset
  property p_one_strobe;
    !(!rd_n && !wr_n);
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("both strobes low");
  property p_strobe_in_cycle;
    (!rd_n || !wr_n) |-> !ce_n && disp_rst_n;
  endproperty
  a_strobe_in_cycle: assert property (p_strobe_in_cycle)
    else $error("strobe outside a select");
  property p_addr_stable;
    (!ce_n)[*2] |-> $stable(addr_lines) && $stable(attr_select_n);
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("address moved while selected");
  // one high cycle is not enough: the gap must span two edges
  property p_ce_gap;
    $rose(ce_n) |=> ce_n;
  endproperty
  a_ce_gap: assert property (p_ce_gap)
    else $error("select gap too short");
  property p_write_drive;
    !wr_n |-> !host_data_oe_n && dev_data_oe_n;
  endproperty
  a_write_drive: assert property (p_write_drive)
    else $error("write without host data");
  // display side: answer a read one cycle on, hold, then let go
  property p_read_answer;
    $fell(rd_n) && !ce_n |=> !dev_data_oe_n;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read not answered");
  property p_read_hold;
    !dev_data_oe_n && !$past(dev_data_oe_n) && !rd_n |-> $stable(dev_data);
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("read data changed");
  property p_release;
    rd_n[*2] |-> dev_data_oe_n;
  endproperty
  a_release: assert property (p_release)
    else $error("display kept driving");
  property p_read_bounded;
    $fell(rd_n) |-> ##[1:8] rd_n;
  endproperty
  a_read_bounded: assert property (p_read_bounded)
    else $error("read strobe stuck");
endmodule

`default_nettype wire

/* test/alnum_display_memory_port_tb.sv */
/*
  Self-checking bench: host and display joined by the bus interface,
  driven over APB. Assumes design files and alnum_params.svh come first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "alnum_params.svh"

module alnum_display_memory_port_tb;
  logic        clk_sys;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  scan_digit;
  logic [2:0]  scan_row;
  logic [7:0]  scan_code_q;
  logic [4:0]  scan_dots_q;
  logic [7:0]  digit_lit_q;
  logic [31:0] rd_q;
  logic        err;
  logic [7:0]  q;
  int          n_fail;
  int          checks;
  int          cyc;
  int          lows;

  alnum_bus_if bus ();

  alnum_host alnum_host_inst (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus));

  // short divider and ratio keep a flash period at 16 cycles
  alnum_display #(.DISP_DIV(2), .FLASH_RATIO(8)) alnum_display_inst (
    .clk_sys(clk_sys), .nrst(nrst), .bus(bus), .scan_digit(scan_digit),
    .scan_row(scan_row), .scan_code_q(scan_code_q),
    .scan_dots_q(scan_dots_q), .digit_lit_q(digit_lit_q));

  alnum_display_memory_port_assertions
    alnum_display_memory_port_assertions_inst (.clk_sys(clk_sys),
    .nrst(nrst), .ce_n(bus.ce_n), .rd_n(bus.rd_n), .wr_n(bus.wr_n),
    .disp_rst_n(bus.disp_rst_n), .attr_select_n(bus.attr_select_n),
    .addr_lines(bus.addr_lines), .host_data_oe_n(bus.host_data_oe_n),
    .dev_data(bus.dev_data), .dev_data_oe_n(bus.dev_data_oe_n));

  // 125 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // a hang anywhere ends here; the run needs about 1100 cycles
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd_q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  // one bus cycle: a = {attr_select_n, addr_lines}; waits for not busy
  task automatic cmd(input logic rd, input logic [5:0] a,
                     input logic [7:0] d);
    apb(1'b1, `REG_CMD, {15'h0, rd, 2'h0, a, d});
    do apb(1'b0, `REG_STATUS, 32'h0); while (rd_q[0] !== 1'b0);
    q = rd_q[15:8];
  endtask

  function automatic logic [4:0] pat(input int r);
    pat = 5'(r * 7 + 3);
  endfunction

  task automatic count_low(input int b);
    lows = 0;
    repeat (64) @(posedge clk_sys) lows += int'(digit_lit_q[b] === 1'b0);
  endtask

  task automatic t_regs;
    apb(1'b0, 12'h00c, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd_q, 32'h0);
    apb(1'b0, `REG_CTRL, 32'h0);
    chk(rd_q, 32'h0);
  endtask

  task automatic t_char;
    for (int i = 0; i < 8; i++)
    begin
      cmd(1'b1, {3'h7, 3'(i)}, 8'h00);
      chk(32'(q), 32'h20);
      cmd(1'b0, {3'h7, 3'(i)}, 8'(8'h41 + i));
    end
    for (int i = 0; i < 8; i++)
    begin
      cmd(1'b1, {3'h7, 3'(i)}, 8'h00);
      chk(32'(q), 32'(8'h41 + i));
      scan_digit <= 3'(i);
      repeat (2) @(posedge clk_sys);
      chk(32'(scan_code_q), 32'(8'h41 + i));
    end
  endtask

  // slot 3 filled, slot 4 touched, slot 3 must survive
  task automatic t_glyph;
    cmd(1'b0, 6'h27, 8'hf3);
    cmd(1'b1, 6'h21, 8'h00);
    chk(32'(q[3:0]), 32'h3);
    for (int r = 0; r < 7; r++)
      cmd(1'b0, {3'h5, 3'(r)}, {3'h7, pat(r)});
    cmd(1'b0, 6'h20, 8'h04);
    cmd(1'b0, 6'h28, 8'h00);
    cmd(1'b0, 6'h20, 8'h03);
    for (int r = 0; r < 7; r++)
    begin
      cmd(1'b1, {3'h5, 3'(r)}, 8'h00);
      chk(32'(q), 32'(pat(r)));
    end
    cmd(1'b0, 6'h3d, 8'hf3);
    scan_digit <= 3'h5;
    for (int r = 0; r < 7; r++)
    begin
      scan_row <= 3'(r);
      repeat (2) @(posedge clk_sys);
      chk(32'(scan_dots_q), 32'(pat(r)));
    end
    cmd(1'b0, 6'h3d, 8'h73);
    repeat (2) @(posedge clk_sys);
    chk(32'(scan_dots_q), 32'h0);
  endtask

  // upper address bits vary on purpose while the select is low
  task automatic t_attr;
    cmd(1'b0, 6'h1a, 8'hff);
    cmd(1'b1, 6'h02, 8'h00);
    chk(32'(q[0]), 32'h1);
    cmd(1'b1, 6'h03, 8'h00);
    chk(32'(q[0]), 32'h0);
    cmd(1'b0, 6'h0a, 8'hfe);
    cmd(1'b1, 6'h12, 8'h00);
    chk(32'(q[0]), 32'h0);
  endtask

  task automatic t_flash;
    cmd(1'b0, 6'h01, 8'h01);
    count_low(1);
    chk(32'(lows), 32'h0);
    cmd(1'b0, 6'h30, 8'h08);
    count_low(1);
    chk(32'(lows), 32'h20);
    count_low(0);
    chk(32'(lows), 32'h0);
    cmd(1'b1, 6'h30, 8'h00);
    chk(32'(q), 32'h08);
    // blink darkens every digit at the same rate, marked or not
    cmd(1'b0, 6'h30, 8'h10);
    count_low(0);
    chk(32'(lows), 32'h20);
    cmd(1'b0, 6'h30, 8'h00);
  endtask

  // a second command while the first still runs is dropped
  task automatic t_busy;
    apb(1'b1, `REG_CMD, {15'h0, 1'b0, 2'h0, 6'h38, 8'h5a});
    apb(1'b1, `REG_CMD, {15'h0, 1'b0, 2'h0, 6'h38, 8'h3c});
    apb(1'b0, `REG_CMD, 32'h0);
    chk(rd_q, {15'h0, 1'b0, 2'h0, 6'h38, 8'h5a});
    do apb(1'b0, `REG_STATUS, 32'h0); while (rd_q[0] !== 1'b0);
    cmd(1'b1, 6'h38, 8'h00);
    chk(32'(q), 32'h5a);
  endtask

  // display reset blanks text, attributes and control; glyphs survive
  task automatic t_reset;
    cmd(1'b0, 6'h30, 8'h08);
    cmd(1'b0, 6'h05, 8'h01);
    apb(1'b1, `REG_CTRL, 32'h1);
    apb(1'b0, `REG_CTRL, 32'h0);
    chk(rd_q, 32'h1);
    apb(1'b1, `REG_CTRL, 32'h0);
    cmd(1'b1, 6'h38, 8'h00);
    chk(32'(q), 32'h20);
    cmd(1'b1, 6'h05, 8'h00);
    chk(32'(q[0]), 32'h0);
    cmd(1'b1, 6'h30, 8'h00);
    chk(32'(q), 32'h0);
    cmd(1'b1, 6'h20, 8'h00);
    chk(32'(q[3:0]), 32'h3);
    cmd(1'b1, 6'h2a, 8'h00);
    chk(32'(q), 32'(pat(2)));
  endtask

  // reset for 20 cycles, then the scenarios in turn
  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    scan_digit = 3'h0;
    scan_row = 3'h0;
    n_fail = 0;
    checks = 0;
    cyc = 0;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    t_regs();
    t_char();
    t_glyph();
    t_attr();
    t_flash();
    t_busy();
    t_reset();
    complete_run();
  end
endmodule

`default_nettype wire
